// ### inc/psop_pkg.sv
// Constants, array layout and reset values for the sum-of-products macrocell array
package psop_pkg;
  // Array inputs: dedicated inputs plus one feedback per macrocell
  localparam int N_ARRAY_IN = 22;
  localparam int N_DED_IN = 12;
  localparam int N_CELL = 10;
  localparam int N_COL = 2 * N_ARRAY_IN;
  localparam int MAX_TERMS = 16;
  localparam int TERM_CNT [N_CELL] = '{8, 10, 12, 14, 16, 16, 14, 12, 10, 8};

  // Term words: async reset term, then per cell an enable term and its sum terms, then the set term
  function automatic int cell_base(input int c);
    int b;
    b = 1;
    for (int k = 0; k < c; k++) begin
      b = b + TERM_CNT[k] + 1;
    end
    return b;
  endfunction

  localparam int AR_TERM_IDX = 0;
  localparam int SP_TERM_IDX = cell_base(N_CELL);
  localparam int N_TERMS = SP_TERM_IDX + 1;

  // Fuse port addresses
  localparam int ADDR_W = 8;
  localparam int CFG_ADDR = N_TERMS;
  localparam int SEC_ADDR = N_TERMS + 1;
  localparam int STORE_WORDS = N_TERMS + 1;

  // Per-cell select fuses inside the configuration word
  localparam int CFG_W = 3;
  localparam int POL_BIT = 0;
  localparam int COMB_BIT = 1;
  localparam int FBSEL_BIT = 2;

  // Values after reset
  localparam logic [N_COL-1:0] FUSE_RST = '0;
  localparam logic [N_CELL-1:0] Q_RST = '0;
  localparam logic [N_CELL-1:0] PIN_RST = '1;
  localparam logic [N_CELL-1:0] OE_RST = '0;
  localparam logic CLK_PIN_RST = 1'b1;
  localparam logic SEC_RST = 1'b0;
endpackage

// ### logic/psop_fuse_store.sv
// Fuse word store with registered read-back
`timescale 1ns/1ps
module psop_fuse_store #(
  parameter int W = 44,
  parameter int DEPTH = 133,
  parameter int AW = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  input wire logic rd_secure,
  output logic [W-1:0] rd_data,
  output logic [W-1:0] fuses [DEPTH]
);
  logic [W-1:0] mem_r [DEPTH];
  logic [W-1:0] mem_nxt [DEPTH];
  logic [W-1:0] rd_data_r;
  logic [W-1:0] rd_data_nxt;

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_nxt[i] = mem_r[i];
    end
    if (wr_en && (wr_addr < AW'(DEPTH))) begin
      mem_nxt[wr_addr] = wr_data;
    end
    rd_data_nxt = rd_data_r;
    if (rd_en) begin
      // Secured part shows every fuse as blown
      if (rd_secure) begin
        rd_data_nxt = '1;
      end else if (rd_addr < AW'(DEPTH)) begin
        rd_data_nxt = mem_r[rd_addr];
      end else begin
        rd_data_nxt = '0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= psop_pkg::FUSE_RST;
      end
      rd_data_r <= '0;
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= mem_nxt[i];
      end
      rd_data_r <= rd_data_nxt;
    end
  end

  assign rd_data = rd_data_r;
  assign fuses = mem_r;
endmodule

// ### logic/psop_array.sv
// Fuse-programmed sum-of-products array with ten output macrocells
// How it works
// - Twenty-two array inputs, ten output macrocells
// - Each cell registered/combinational, either polarity
// - Feedback from register or from pin
// - Own enable product term per output
// - Eight to sixteen sum terms per cell
// - Set term loads ones on clock edge
// - Reset term clears registers at once
// - One set and reset term for all
// - Pin after set/reset follows polarity
// - Preload forces registers to chosen values
// - Disabled output pins usable as inputs
// - Power-up clear: pin shows inverse-polarity level
// - Security fuse blocks read-back, shows blown
// - Fuse zero intact, one blown
// - Select fuses choose mode, feedback, polarity
// - Registered cell, driver off: pin feeds array
//
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module psop_array (
  input wire logic clk,
  input wire logic resetn,
  input wire logic array_clk,
  input wire logic [psop_pkg::N_DED_IN-2:0] ded_in,
  input wire logic [psop_pkg::N_CELL-1:0] pin_i,
  output logic [psop_pkg::N_CELL-1:0] pin_o,
  output logic [psop_pkg::N_CELL-1:0] pin_oe,
  input wire logic preload_en,
  input wire logic [psop_pkg::N_CELL-1:0] preload_sel,
  input wire logic [psop_pkg::ADDR_W-1:0] fuse_addr,
  input wire logic [psop_pkg::N_COL-1:0] fuse_wdata,
  input wire logic fuse_wr,
  input wire logic fuse_rd,
  output logic [psop_pkg::N_COL-1:0] fuse_rdata
);
  localparam int NC = psop_pkg::N_CELL;

  function automatic logic pterm(input logic [psop_pkg::N_COL-1:0] fw, input logic [psop_pkg::N_COL-1:0] cols);
    // Intact fuse keeps the literal in the term
    return &(cols | fw);
  endfunction

  logic [psop_pkg::N_COL-1:0] fuses [psop_pkg::STORE_WORDS];
  logic [psop_pkg::N_COL-1:0] cfg_word;
  logic [NC-1:0] pol;
  logic [NC-1:0] comb_mode;
  logic [NC-1:0] fb_pin;

  logic [NC-1:0] q_r;
  logic [NC-1:0] q_nxt;
  logic [NC-1:0] pin_o_r;
  logic [NC-1:0] pin_o_nxt;
  logic [NC-1:0] pin_oe_r;
  logic [NC-1:0] pin_oe_nxt;
  logic clk_pin_d_r;
  logic clk_pin_d_nxt;
  logic sec_r;
  logic sec_nxt;

  logic clk_rise;
  logic [psop_pkg::N_ARRAY_IN-1:0] ain;
  logic [psop_pkg::N_COL-1:0] cols;
  logic [NC-1:0] sum;
  logic [NC-1:0] oe_term;
  logic ar_term;
  logic sp_term;

  assign cfg_word = fuses[psop_pkg::CFG_ADDR];
  assign clk_rise = array_clk & ~clk_pin_d_r;

  // Decode the three select fuses of each cell
  always_comb begin
    for (int c = 0; c < NC; c++) begin
      pol[c] = cfg_word[psop_pkg::CFG_W * c + psop_pkg::POL_BIT];
      comb_mode[c] = cfg_word[psop_pkg::CFG_W * c + psop_pkg::COMB_BIT];
      // Pin feedback when path select blown or cell combinational
      // Disabled driver on a registered cell feeds the pin back
      fb_pin[c] = comb_mode[c] | cfg_word[psop_pkg::CFG_W * c + psop_pkg::FBSEL_BIT] | ~pin_oe_r[c];
    end
  end

  // Array inputs: clock pin, dedicated inputs, cell feedbacks
  // Pin feedback lets any undriven output act as an input
  always_comb begin
    ain = '0;
    ain[0] = array_clk;
    for (int j = 1; j < psop_pkg::N_DED_IN; j++) begin
      ain[j] = ded_in[j-1];
    end
    for (int c = 0; c < NC; c++) begin
      ain[psop_pkg::N_DED_IN + c] = fb_pin[c] ? pin_i[c] : q_r[c];
    end
    for (int j = 0; j < psop_pkg::N_ARRAY_IN; j++) begin
      cols[2*j] = ain[j];
      cols[2*j+1] = ~ain[j];
    end
  end

  // Sum of the cell's allotted product terms
  always_comb begin
    for (int c = 0; c < NC; c++) begin
      sum[c] = 1'b0;
      for (int t = 0; t < psop_pkg::MAX_TERMS; t++) begin
        if (t < psop_pkg::TERM_CNT[c]) begin
          sum[c] = sum[c] | pterm(fuses[psop_pkg::cell_base(c) + 1 + t], cols);
        end
      end
      oe_term[c] = pterm(fuses[psop_pkg::cell_base(c)], cols);
    end
    // Single shared set and reset terms
    ar_term = pterm(fuses[psop_pkg::AR_TERM_IDX], cols);
    sp_term = pterm(fuses[psop_pkg::SP_TERM_IDX], cols);
  end

  // Macrocell registers, pin levels and drivers
  always_comb begin
    q_nxt = q_r;
    clk_pin_d_nxt = array_clk;
    for (int c = 0; c < NC; c++) begin
      if (clk_rise) begin
        if (preload_en) begin
          // Preload captures the applied pin level
          if (preload_sel[c]) begin
            q_nxt[c] = pin_i[c] ^ ~pol[c];
          end
        end else if (sp_term) begin
          // Synchronous set on array clock edge
          q_nxt[c] = 1'b1;
        end else begin
          q_nxt[c] = sum[c];
        end
      end
    end
    // Reset term wins over any clock edge
    if (ar_term) begin
      q_nxt = '0;
    end
    for (int c = 0; c < NC; c++) begin
      // Registered or combinational path with polarity
      // Pin level is sum or register through polarity
      pin_o_nxt[c] = comb_mode[c] ? (sum[c] ^ ~pol[c]) : (q_nxt[c] ^ ~pol[c]);
      // Enable false floats the pin, register keeps running
      pin_oe_nxt[c] = oe_term[c] & ~preload_en;
    end
    sec_nxt = sec_r;
    if (fuse_wr && (fuse_addr == psop_pkg::ADDR_W'(psop_pkg::SEC_ADDR)) && fuse_wdata[0]) begin
      sec_nxt = 1'b1;
    end
  end

  // Power-up clear: registers zero, pins at inverse level
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q_r <= psop_pkg::Q_RST;
      pin_o_r <= psop_pkg::PIN_RST;
      pin_oe_r <= psop_pkg::OE_RST;
      clk_pin_d_r <= psop_pkg::CLK_PIN_RST;
      sec_r <= psop_pkg::SEC_RST;
    end else begin
      q_r <= q_nxt;
      pin_o_r <= pin_o_nxt;
      pin_oe_r <= pin_oe_nxt;
      clk_pin_d_r <= clk_pin_d_nxt;
      sec_r <= sec_nxt;
    end
  end

  assign pin_o = pin_o_r;
  assign pin_oe = pin_oe_r;

  // Fuse words held static in the store
  psop_fuse_store #(
    .W(psop_pkg::N_COL),
    .DEPTH(psop_pkg::STORE_WORDS),
    .AW(psop_pkg::ADDR_W)
  ) u_store (
    .clk(clk),
    .resetn(resetn),
    .wr_en(fuse_wr),
    .wr_addr(fuse_addr),
    .wr_data(fuse_wdata),
    .rd_en(fuse_rd),
    .rd_addr(fuse_addr),
    .rd_secure(sec_r),
    .rd_data(fuse_rdata),
    .fuses(fuses)
  );
endmodule

// ### tb/psop_monitor.sv
// Port checker for the macrocell array
`timescale 1ns/1ps
module psop_monitor (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [9:0] pin_o,
  input wire logic [9:0] pin_oe,
  input wire logic preload_en,
  input wire logic [7:0] fuse_addr,
  input wire logic [43:0] fuse_wdata,
  input wire logic fuse_wr,
  input wire logic fuse_rd,
  input wire logic [43:0] fuse_rdata
);
  logic sec_r;
  logic dirty_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Security blown, any fuse write or preload since reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) {sec_r, dirty_r} <= 2'b00;
    else {sec_r, dirty_r} <= {sec_r | (fuse_wr & fuse_addr == 8'h85 & fuse_wdata[0]), dirty_r | fuse_wr | preload_en};
  end
  property p_pre; preload_en |=> pin_oe == '0; endproperty
  a_pre: assert property (p_pre) else $error("oe in preload");
  property p_hold; !fuse_rd |=> $stable(fuse_rdata); endproperty
  a_hold: assert property (p_hold) else $error("rdata moved");
  property p_sec; sec_r && fuse_rd |=> fuse_rdata == '1; endproperty
  a_sec: assert property (p_sec) else $error("secured read");
  property p_blow; fuse_wr && fuse_addr == 8'h85 && fuse_wdata[0] ##2 fuse_rd |=> fuse_rdata == '1; endproperty
  a_blow: assert property (p_blow) else $error("blow late");
  property p_gap; fuse_rd && fuse_addr > 8'h84 && !sec_r |=> fuse_rdata == '0; endproperty
  a_gap: assert property (p_gap) else $error("unmapped read");
  property p_back; fuse_wr && fuse_addr < 8'h84 && !sec_r ##1 !fuse_wr ##1 fuse_rd && fuse_addr == $past(fuse_addr, 2)
    |=> fuse_rdata == $past(fuse_wdata, 3); endproperty
  a_back: assert property (p_back) else $error("readback");
  property p_pin; !dirty_r |-> pin_o == '1; endproperty
  a_pin: assert property (p_pin) else $error("clear level");
  property p_oe; !dirty_r |-> pin_oe == '0; endproperty
  a_oe: assert property (p_oe) else $error("oe unfused");
  c_pre: cover property (preload_en ##1 !preload_en);
  c_sec: cover property (sec_r && fuse_rd);
  c_oe: cover property ($rose(pin_oe[0]));
endmodule
bind psop_array psop_monitor mon_u (.clk, .resetn, .pin_o, .pin_oe, .preload_en, .fuse_addr, .fuse_wdata,
  .fuse_wr, .fuse_rd, .fuse_rdata);

// ### tb/psop_partner.sv
// System logic that drives the array clock and dedicated inputs
`timescale 1ns/1ps
module psop_partner (
  input wire logic clk,
  input wire logic resetn,
  input wire logic tick,
  input wire logic [10:0] nxt_in,
  output logic array_clk,
  output logic [10:0] ded_in
);
  logic [2:0] cnt_r;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= 3'h0;
      ded_in <= 11'h000;
      array_clk <= 1'b0;
    end else begin
      if (tick) ded_in <= nxt_in;
      cnt_r <= (tick || cnt_r != 3'h0) ? cnt_r + 3'h1 : 3'h0;
      array_clk <= cnt_r == 3'h3 || cnt_r == 3'h4;
    end
  end
endmodule

// ### tb/testbench.sv
// Self-checking bench for the macrocell array
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin num_errors++; $display("CHECK FAILED %0t %h %h", $time, g, e); end end
module testbench;
  logic clk = 1'b0, resetn = 1'b0, array_clk, fuse_wr = 1'b0, fuse_rd = 1'b0, preload_en = 1'b0;
  logic tick = 1'b0, pin_chk = 1'b0, rd_d = 1'b0, noise = 1'b0;
  logic [10:0] ded_in, nxt_in = 11'h000;
  logic [9:0] pin_i, pin_o, pin_oe, preload_sel = 10'h000, ext_en = 10'h000;
  logic [7:0] fuse_addr = 8'h00, ra;
  logic [43:0] fuse_wdata = 44'h0, fuse_rdata, d, ex;
  logic [43:0] exp_q[$];
  int num_errors = 0, check_count = 0;
  always #4 clk = ~clk;
  always @(posedge clk) noise <= ~noise;
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ~ext_en & {10{noise}});
  psop_array dut_u (.clk, .resetn, .array_clk, .ded_in, .pin_i, .pin_o, .pin_oe, .preload_en, .preload_sel,
    .fuse_addr, .fuse_wdata, .fuse_wr, .fuse_rd, .fuse_rdata);
  psop_partner prt_u (.clk, .resetn, .tick, .nxt_in, .array_clk, .ded_in);
  always @(posedge clk) begin
    rd_d <= fuse_rd;
    if (rd_d || pin_chk) begin
      ex = exp_q.pop_front();
      if (rd_d) `CHK(fuse_rdata, ex)
      else `CHK(44'({pin_oe, pin_o}), ex)
    end
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [43:0] v);
    if (!w) exp_q.push_back(v);
    fuse_wr <= w;
    fuse_rd <= !w;
    fuse_addr <= a;
    fuse_wdata <= v;
    @(posedge clk);
    fuse_wr <= 1'b0;
    fuse_rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic step(input logic [10:0] v, input logic [19:0] e);
    nxt_in <= v;
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    repeat (8) @(posedge clk);
    exp_q.push_back(44'(e));
    pin_chk <= 1'b1;
    @(posedge clk);
    pin_chk <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rst();
    resetn <= 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
  endtask
  task automatic stop_test();
    if (num_errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #400000;
    num_errors++;
    stop_test();
  end
  initial begin
    void'($urandom(40));
    rst();
    step(11'h000, {10'h000, 10'h3ff});
    for (int i = 0; i < 4; i++) begin
      ra = 8'($urandom_range(130, 1));
      d = 44'({$urandom(), $urandom()});
      bus(1'b1, ra, d);
      bus(1'b0, ra, d);
    end
    bus(1'b0, 8'hf0, 44'h0);
    rst();
    bus(1'b1, 8'h01, ~44'h4);
    bus(1'b1, 8'h02, ~44'h10);
    bus(1'b1, 8'h83, ~44'h40);
    bus(1'b1, 8'h00, ~44'h100);
    bus(1'b1, 8'h84, 44'h1);
    step(11'h003, {10'h001, 10'h3ff});
    step(11'h001, {10'h001, 10'h3fe});
    step(11'h004, {10'h000, 10'h001});
    step(11'h008, {10'h000, 10'h3fe});
    // Combinational cell ignores the reset term held by ded_in[3]
    bus(1'b1, 8'h84, 44'h3);
    step(11'h00b, {10'h001, 10'h3ff});
    bus(1'b1, 8'h84, 44'h1);
    preload_en <= 1'b1;
    preload_sel <= 10'h002;
    ext_en <= 10'h002;
    step(11'h000, {10'h000, 10'h3fc});
    ext_en <= 10'h000;
    @(posedge clk);
    preload_en <= 1'b0;
    bus(1'b0, 8'h02, ~44'h10);
    bus(1'b1, 8'h85, 44'h1);
    bus(1'b0, 8'h02, ~44'h0);
    stop_test();
  end
endmodule
